// ==== logic/sec_gate_pkg.sv ====
// Purpose: Shared constants for the monitor security gate.
// Assumes: 16-bit CPU address space, 8-bit data.
// Notes:   The flash window bounds are a plain default, not a property of any part.
`default_nettype none
package sec_gate_pkg;
  localparam logic [15:0] SEC_BASE    = 16'hfff6;
  localparam logic [3:0]  SEC_LEN     = 4'h8;
  localparam logic [15:0] FLASH_LO    = 16'hc000;
  localparam logic [15:0] FLASH_HI    = 16'hffff;
  localparam logic [15:0] FLAG_ADDR   = 16'h0060;
  localparam logic [7:0]  FLAG_MASK   = 8'h40;
  localparam logic [7:0]  BLANK_BYTE  = 8'hff;
  localparam logic [7:0]  BAD_BYTE    = 8'h00;

  typedef enum logic [2:0] {
    ST_STRAP   = 3'b000,
    ST_COLLECT = 3'b001,
    ST_PASS    = 3'b010,
    ST_FAIL    = 3'b011,
    ST_USER    = 3'b100
  } gate_state_e;

  function automatic logic in_flash(input logic [15:0] addr);
    in_flash = (addr >= FLASH_LO) && (addr <= FLASH_HI);
  endfunction : in_flash
endpackage : sec_gate_pkg
`default_nettype wire

// ==== logic/key_compare.sv ====
// Purpose: Takes eight host bytes and compares each with the stored key byte.
// Assumes: key_data_i is the flash content at key_addr_o in the same cycle.
// Notes:   A single mismatch anywhere makes the whole comparison fail.
`default_nettype none
module key_compare
  import sec_gate_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        start_i,
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_data_i,
  input  wire logic [7:0]  key_data_i,
  output logic      [15:0] key_addr_o,
  output logic             done_o,
  output logic             match_o
);
  logic [3:0] count;
  logic       busy;
  logic       bad;
  logic       last;

  assign last       = (count == SEC_LEN - 4'h1);
  assign key_addr_o = SEC_BASE + {12'h000, count};

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      busy <= 1'b0;
      count <= 4'h0;
    end else if (start_i) begin
      busy <= 1'b1;
      count <= 4'h0;
    end else if (busy && rx_valid_i) begin
      count <= count + 4'h1;
      if (last) begin
        busy <= 1'b0;
      end
    end
  end

  // Mismatch is sticky so the verdict covers all eight bytes.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || start_i) begin
      bad <= 1'b0;
    end else if (busy && rx_valid_i && (rx_data_i != key_data_i)) begin
      bad <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      done_o  <= 1'b0;
      match_o <= 1'b0;
    end else begin
      done_o  <= busy && rx_valid_i && last;
      match_o <= !bad && (rx_data_i == key_data_i);
    end
  end
endmodule : key_compare
`default_nettype wire

// ==== logic/monitor_security_gate.sv ====
// Purpose: Security check on monitor mode entry; gates flash reads and fetches.
// Assumes: rst_n_i is the power-on reset; monitor strap stable at its release.
// Notes:   The verdict is frozen until the next power-on reset.
`default_nettype none
module monitor_security_gate
  import sec_gate_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        mon_strap_i,
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_data_i,
  input  wire logic [7:0]  key_data_i,
  input  wire logic        cpu_rd_i,
  input  wire logic        cpu_fetch_i,
  input  wire logic [15:0] cpu_addr_i,
  input  wire logic [7:0]  flash_data_i,
  input  wire logic        erase_req_i,
  input  wire logic        erase_done_i,
  output logic      [15:0] key_addr_o,
  output logic      [7:0]  rd_data_o,
  output logic             rd_valid_o,
  output logic             illegal_rst_o,
  output logic             brk_o,
  output logic             ram_we_o,
  output logic      [15:0] ram_addr_o,
  output logic      [7:0]  ram_mask_o,
  output logic             mon_active_o,
  output logic             flash_open_o,
  output logic             erase_go_o,
  output logic             key_blank_o
);
  gate_state_e state;
  gate_state_e next_state;
  logic        cmp_start;
  logic        cmp_done;
  logic        cmp_match;
  logic        locked;

  key_compare key_compare_inst (
    .sys_clk_i  (sys_clk_i),
    .rst_n_i    (rst_n_i),
    .start_i    (cmp_start),
    .rx_valid_i (rx_valid_i),
    .rx_data_i  (rx_data_i),
    .key_data_i (key_data_i),
    .key_addr_o (key_addr_o),
    .done_o     (cmp_done),
    .match_o    (cmp_match)
  );

  // The strap is sampled in the first cycle after reset, never under reset.
  assign cmp_start = (state == ST_STRAP) && mon_strap_i;
  assign locked    = (state == ST_FAIL);

  always_comb begin
    next_state = state;
    unique case (state)
      ST_STRAP:   next_state = mon_strap_i ? ST_COLLECT : ST_USER;
      ST_COLLECT: begin
        if (cmp_done) begin
          next_state = cmp_match ? ST_PASS : ST_FAIL;
        end
      end
      ST_PASS:    next_state = ST_PASS;
      ST_FAIL:    next_state = ST_FAIL;
      ST_USER:    next_state = ST_USER;
      default:    next_state = ST_FAIL;
    endcase
  end

  // No path leaves a verdict but reset, so a host must power-cycle to retry.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state <= ST_STRAP;
    end else begin
      state <= next_state;
    end
  end

  // User mode leaves flash open; the key only matters on monitor entry.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      mon_active_o <= 1'b0;
      flash_open_o <= 1'b0;
    end else begin
      mon_active_o <= (next_state == ST_COLLECT) || (next_state == ST_PASS)
                      || (next_state == ST_FAIL);
      flash_open_o <= (next_state == ST_PASS) || (next_state == ST_USER);
    end
  end

  // Break goes out the cycle after the eighth byte is judged.
  // Bytes past the eighth are dropped by the comparator, so no second break follows.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      brk_o <= 1'b0;
    end else begin
      brk_o <= (state == ST_COLLECT) && cmp_done;
    end
  end

  // Only the flag bit is written so other contents of the byte survive.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      ram_we_o   <= 1'b0;
      ram_addr_o <= FLAG_ADDR;
      ram_mask_o <= FLAG_MASK;
    end else begin
      ram_we_o   <= (state == ST_COLLECT) && cmp_done && cmp_match;
      ram_addr_o <= FLAG_ADDR;
      ram_mask_o <= FLAG_MASK;
    end
  end

  // While the key is still being checked flash is treated as locked too.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rd_valid_o <= 1'b0;
      rd_data_o  <= BAD_BYTE;
    end else begin
      rd_valid_o <= cpu_rd_i;
      if (cpu_rd_i) begin
        if (in_flash(cpu_addr_i) && !flash_open_o) begin
          rd_data_o <= BAD_BYTE;
        end else begin
          rd_data_o <= flash_data_i;
        end
      end
    end
  end

  // Fetches during the key check are not reset; only a settled failure locks code.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      illegal_rst_o <= 1'b0;
    end else begin
      illegal_rst_o <= cpu_fetch_i && in_flash(cpu_addr_i) && locked;
    end
  end

  // Erase is honoured only after a failed check; the flash controller
  // reports completion, after which the key bytes read as blank.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      erase_go_o  <= 1'b0;
      key_blank_o <= 1'b0;
    end else begin
      erase_go_o <= erase_req_i && locked;
      if (erase_done_i && locked) begin
        key_blank_o <= 1'b1;
      end
    end
  end

  // The comparator result is only valid in the cycle its done strobe stands.
  compare_verdict_a : assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state == ST_COLLECT && cmp_done) |=> (state == ($past(cmp_match) ? ST_PASS : ST_FAIL)))
    else $error("Verdict does not follow comparison.");

  locked_read_a : assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (cpu_rd_i && in_flash(cpu_addr_i) && locked) |=> (rd_valid_o && rd_data_o == BAD_BYTE))
    else $error("Locked flash read leaked data.");

  locked_fetch_a : assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (cpu_fetch_i && in_flash(cpu_addr_i) && locked) |=> illegal_rst_o)
    else $error("Locked flash fetch did not reset.");

  break_timing_a : assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    brk_o |-> ($past(cmp_done) && $past(state) == ST_COLLECT && state != ST_COLLECT))
    else $error("Break sent before eighth byte.");

  pass_flag_a : assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    ram_we_o |-> (state == ST_PASS && ram_addr_o == FLAG_ADDR && ram_mask_o == FLAG_MASK
      && brk_o))
    else $error("Flag write without pass.");

  erase_blank_a : assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (erase_done_i && locked) |=> (key_blank_o && state == ST_FAIL))
    else $error("Erase completion not recorded.");

  verdict_hold_a : assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state == ST_PASS || state == ST_FAIL) |=> $stable(state) && $stable(flash_open_o))
    else $error("Verdict changed before reset.");

  unlock_match_a : assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(flash_open_o) && mon_active_o |-> $past(cmp_match) && $past(cmp_done))
    else $error("Flash opened without a match.");

  strap_entry_a : assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state == ST_STRAP && mon_strap_i) |=> (state == ST_COLLECT && mon_active_o))
    else $error("Monitor entry skipped the key check.");

  fail_monitor_a : assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    locked |-> (mon_active_o && !flash_open_o))
    else $error("Failed check left monitor mode or opened flash.");

  early_break_a : assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state == ST_COLLECT && !cmp_done) |=> !brk_o)
    else $error("Break raised while bytes were still pending.");

  single_break_a : assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    brk_o |=> !brk_o)
    else $error("Break held longer than one cycle.");

  erase_gate_a : assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    erase_go_o |-> ($past(erase_req_i) && locked))
    else $error("Erase accepted outside a failed check.");

  blank_hold_a : assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    key_blank_o |=> key_blank_o)
    else $error("Blank record lost before reset.");
endmodule : monitor_security_gate
`default_nettype wire

// ==== tb/flash_model.sv ====
// Purpose: Flash model holding the security key and serving mass erase.
// Assumes: Reads are combinational, as the gate expects.
// Notes:   Other flash returns an address pattern, so a stale value cannot pass.
`default_nettype none
module flash_model
  import sec_gate_pkg::*;
#(
  parameter logic [63:0] KEY = 64'h0
)(
  input  wire logic        sys_clk_i,
  input  wire logic [15:0] key_addr_i,
  input  wire logic [15:0] cpu_addr_i,
  input  wire logic        erase_go_i,
  output logic      [7:0]  key_data_o,
  output logic      [7:0]  flash_data_o,
  output var logic         erase_done_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [63:0] key = KEY;
  initial erase_done_o = 1'b0;

  function automatic logic [7:0] peek(input logic [15:0] a);
    logic [15:0] k;
    k = a - SEC_BASE;
    peek = (a >= SEC_BASE && k < 16'h0008) ? key[{k[2:0], 3'b000} +: 8] : a[7:0] ^ a[15:8];
  endfunction : peek

  assign key_data_o   = peek(key_addr_i);
  assign flash_data_o = peek(cpu_addr_i);

  always @(posedge sys_clk_i) begin
    if (erase_go_i === 1'b1) begin
      repeat (3) @(posedge sys_clk_i);
      key          <= {8{BLANK_BYTE}};
      erase_done_o <= 1'b1;
      @(posedge sys_clk_i);
      erase_done_o <= 1'b0;
    end
  end
endmodule : flash_model
`default_nettype wire

// ==== tb/monitor_security_gate_test.sv ====
// Purpose: Self-checking bench for the monitor security gate.
// Assumes: Inputs change on falling edges only.
// Notes:   Each scenario starts from its own power-on reset.
`default_nettype none
module monitor_security_gate_test;
  import sec_gate_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [63:0] KEY = 64'h8877665544332211;
  logic sys_clk_i = 0, rst_n_i = 0, mon_strap_i = 0, rx_valid_i = 0;
  logic cpu_rd_i = 0, cpu_fetch_i = 0, erase_req_i = 0;
  logic [7:0]  rx_data_i  = 8'h00;
  logic [15:0] cpu_addr_i = 16'h0000;
  logic [7:0]  key_data, flash_data, rd_data_o, ram_mask_o;
  logic [15:0] key_addr, ram_addr_o;
  logic        erase_done, rd_valid_o, illegal_rst_o, brk_o, ram_we_o;
  logic        mon_active_o, flash_open_o, erase_go_o, key_blank_o;
  int          mismatches = 0, comparisons = 0, cycles = 0, brks = 0;

  monitor_security_gate monitor_security_gate_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .mon_strap_i(mon_strap_i), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
    .key_data_i(key_data), .cpu_rd_i(cpu_rd_i), .cpu_fetch_i(cpu_fetch_i),
    .cpu_addr_i(cpu_addr_i), .flash_data_i(flash_data), .erase_req_i(erase_req_i),
    .erase_done_i(erase_done), .key_addr_o(key_addr), .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o), .illegal_rst_o(illegal_rst_o), .brk_o(brk_o),
    .ram_we_o(ram_we_o), .ram_addr_o(ram_addr_o), .ram_mask_o(ram_mask_o),
    .mon_active_o(mon_active_o), .flash_open_o(flash_open_o), .erase_go_o(erase_go_o),
    .key_blank_o(key_blank_o));
  flash_model #(.KEY(KEY)) flash_model_inst (.sys_clk_i(sys_clk_i), .key_addr_i(key_addr),
    .cpu_addr_i(cpu_addr_i), .erase_go_i(erase_go_o), .key_data_o(key_data),
    .flash_data_o(flash_data), .erase_done_o(erase_done));

  initial begin
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      summarize();
    end
  end

  // Counted at the falling edge, away from the edge that launches the pulse.
  always @(negedge sys_clk_i) begin
    if (brk_o === 1'b1) brks++;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic por(input logic strap);
    rst_n_i = 1'b0;
    mon_strap_i = strap;
    repeat (10) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    @(negedge sys_clk_i);
    brks = 0;
  endtask : por

  // One byte every other cycle, so the strobe is low at the edge between bytes.
  task automatic send(input logic [7:0] b);
    rx_data_i = b;
    rx_valid_i = 1'b1;
    @(negedge sys_clk_i);
    rx_valid_i = 1'b0;
    @(negedge sys_clk_i);
  endtask : send

  task automatic entry(input logic [63:0] k, input logic ok);
    for (int i = 0; i < 7; i++) send(k[i*8 +: 8]);
    repeat (3) @(negedge sys_clk_i);
    chk("early_brk", 16'h0000, 16'(brks));
    send(k[63:56]);
    chk("brk", 16'h0001, 16'(brk_o));
    chk("ram_we", 16'(ok), 16'(ram_we_o));
    if (ok) chk("ram_addr", FLAG_ADDR, ram_addr_o);
    if (ok) chk("ram_mask", 16'(FLAG_MASK), 16'(ram_mask_o));
    chk("flash_open", 16'(ok), 16'(flash_open_o));
  endtask : entry

  task automatic access(input logic fetch, input logic [15:0] a, input logic [7:0] exp);
    cpu_addr_i = a;
    cpu_rd_i = ~fetch;
    cpu_fetch_i = fetch;
    @(negedge sys_clk_i);
    cpu_rd_i = 1'b0;
    cpu_fetch_i = 1'b0;
    if (fetch) chk("illegal_rst", 16'(exp), 16'(illegal_rst_o));
    else chk("rd_data", 16'(exp), 16'(rd_data_o));
    chk("rd_valid", 16'(!fetch), 16'(rd_valid_o));
    @(negedge sys_clk_i);
  endtask : access

  task automatic t_pass();
    por(1'b1);
    entry(KEY, 1'b1);
    access(1'b0, 16'hfff6, KEY[7:0]);
    access(1'b0, 16'hc123, 8'he2);
    access(1'b1, 16'hc000, 8'h00);
    erase_req_i = 1'b1;
    @(negedge sys_clk_i);
    erase_req_i = 1'b0;
    chk("erase_refused", 16'h0000, 16'(erase_go_o));
    send(8'h00);
    repeat (4) @(negedge sys_clk_i);
    chk("held_open", 16'h0001, 16'(flash_open_o));
    chk("brk_count", 16'h0001, 16'(brks));
  endtask : t_pass

  task automatic t_early_miss();
    por(1'b1);
    entry(KEY ^ 64'h1, 1'b0);
    access(1'b0, 16'hc123, BAD_BYTE);
    access(1'b1, 16'hfff6, 8'h01);
  endtask : t_early_miss

  task automatic t_user();
    por(1'b0);
    for (int i = 0; i < 8; i++) send(KEY[i*8 +: 8]);
    repeat (3) @(negedge sys_clk_i);
    chk("user_brk", 16'h0000, 16'(brks));
    chk("user_mon", 16'h0000, 16'(mon_active_o));
    chk("user_open", 16'h0001, 16'(flash_open_o));
    access(1'b0, 16'hc123, 8'he2);
  endtask : t_user

  task automatic t_fail_erase();
    int n;
    por(1'b1);
    entry(KEY ^ {8'h01, 56'h0}, 1'b0);
    chk("mon_active", 16'h0001, 16'(mon_active_o));
    access(1'b0, 16'hfff6, BAD_BYTE);
    access(1'b1, 16'he000, 8'h01);
    erase_req_i = 1'b1;
    @(negedge sys_clk_i);
    erase_req_i = 1'b0;
    chk("erase_go", 16'h0001, 16'(erase_go_o));
    n = 0;
    while (key_blank_o !== 1'b1 && n < 10) begin
      @(negedge sys_clk_i);
      n++;
    end
    chk("key_blank", 16'h0001, 16'(key_blank_o));
    chk("held_closed", 16'h0000, 16'(flash_open_o));
    por(1'b1);
    chk("blank_clear", 16'h0000, 16'(key_blank_o));
    entry({8{BLANK_BYTE}}, 1'b1);
    access(1'b0, 16'hfff6, BLANK_BYTE);
  endtask : t_fail_erase

  task automatic summarize();
    if (mismatches == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  initial begin
    t_pass();
    t_early_miss();
    t_user();
    t_fail_erase();
    summarize();
  end
endmodule : monitor_security_gate_test
`default_nettype wire
